// *** ppi_channel.sv ***
// Function
// R1: Per-channel PIPE 2.0 interface block
// R2: Block always in datapath, no bypass
// R3: MAC request forces transmitter electrical idle
// R4: MAC request launches receiver detection
// R5: Compliance disparity override from MAC
// R6: Low-power states only force electrical idle; the code also forces it on MAC request and while detecting
// R7: Completion pulse on PHY status
// R8: Three-bit encoded receiver status
// R9: Gen1 ten-bit PMA, eight-bit MAC
// R10: Aligner locks on K28.5 either disparity
// R11: Rate match absorbs 300 ppm offset
// R12: Low-latency option sets FIFO low-latency
// R13: MAC width selectable eight or sixteen
// R14: Bonded widths x1 to x8; the LANES parameter is accepted but no logic uses it
// R15: Detect/loopback meaning depends on power state
// R16: Detection timed by external 125 MHz
// R17: Idle held while MAC idle input high
// R18: PHY status lasts one cycle
`include "ppi_params.svh"
module ppi_channel import ppi_pkg::*; #( // R1
  parameter int DW = 8,
  parameter int LANES = 1, // R14
  parameter int DET_CYCLES = `PPI_DET_CYCLES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [DW-1:0] tx_data,
  input wire logic tx_datak,
  input wire logic tx_elecidle,
  input wire logic tx_compliance,
  input wire logic tx_detect_loop,
  input wire logic [1:0] power_down,
  input wire logic rate_gen2,
  input wire logic low_latency,
  input wire logic [9:0] pma_rx_word,
  input wire logic pma_rx_valid,
  input wire logic rx_dec_err,
  input wire logic rx_disp_err,
  input wire logic rx_rm_add,
  input wire logic rx_rm_drop,
  input wire logic rx_rm_over,
  input wire logic rx_rm_under,
  input wire logic [DW-1:0] rx_dec_data,
  input wire logic rx_dec_k,
  input wire logic det_tick,
  input wire logic far_rx_present,
  input wire logic rx_ready,
  output logic [DW-1:0] enc_data,
  output logic enc_k,
  output logic enc_disp_force,
  output logic enc_disp_neg,
  output logic tx_buf_idle,
  output logic det_start,
  output logic loopback_on,
  output logic rm_low_latency,
  output logic rx_synced,
  output logic [DW-1:0] rx_data,
  output logic rx_datak,
  output logic rx_valid,
  output logic phy_status,
  output logic [2:0] rx_status
);
  // ----------------------------------------
  // Input synchronisers for pin-level inputs
  // ----------------------------------------
  logic [1:0] tick_sync; // Detection clock tick, crosses in
  logic [1:0] pres_sync; // Far-end sense result
  logic tick_q; // Edge memory of synced tick
  logic tick_rise;

  // R16 tick from the 125 MHz detect clock crosses two flops
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_sync <= 2'h0;
      pres_sync <= 2'h0;
      tick_q <= 1'b0;
    end else begin
      tick_sync <= {tick_sync[0], det_tick};
      pres_sync <= {pres_sync[0], far_rx_present};
      tick_q <= tick_sync[1];
    end
  end
  assign tick_rise = tick_sync[1] & ~tick_q; // R16

  // ----------------------------------------
  // Receiver detection sequencer
  // ----------------------------------------
  ppi_det_t det_state; // Sequencer state
  ppi_det_t next_det_state;
  logic [15:0] det_cnt; // Measurement window count
  logic [15:0] next_det_cnt;
  logic det_found; // Captured result
  logic next_det_found;
  logic det_req;

  // Detection only in P1; P0 gives loopback instead
  assign det_req = tx_detect_loop && (power_down == `PPI_P1); // R15 R4

  // Next state for detection
  always_comb begin
    next_det_state = det_state;
    next_det_cnt = det_cnt;
    next_det_found = det_found;
    unique case (det_state)
      PPI_IDLE: begin
        // Wait for a request
        if (det_req) begin
          next_det_state = PPI_CHARGE; // R4
          next_det_cnt = 16'h0000;
        end
      end
      PPI_CHARGE: begin
        // Step applied, start on a detect-clock tick
        if (tick_rise) begin
          next_det_state = PPI_SENSE;
        end
      end
      PPI_SENSE: begin
        // Time window counted in detect-clock ticks
        if (tick_rise) begin
          next_det_cnt = det_cnt + 16'h0001; // R16
        end
        if (det_cnt >= 16'(DET_CYCLES)) begin
          next_det_state = PPI_REPORT;
          next_det_found = pres_sync[1];
        end
      end
      PPI_REPORT: begin
        // Single report, then wait for request drop
        if (!tx_detect_loop) begin
          next_det_state = PPI_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      det_state <= PPI_IDLE;
      det_cnt <= 16'h0000;
      det_found <= 1'b0;
    end else begin
      det_state <= next_det_state;
      det_cnt <= next_det_cnt;
      det_found <= next_det_found;
    end
  end

  // ----------------------------------------
  // Power state tracking
  // ----------------------------------------
  logic [1:0] pwr_cur; // Accepted power state
  logic [2:0] pwr_cnt; // Transition settle timer
  logic [1:0] next_pwr_cur;
  logic [2:0] next_pwr_cnt;
  logic pwr_done;

  // Accept any state; completion after a short settle
  always_comb begin
    next_pwr_cur = pwr_cur;
    next_pwr_cnt = pwr_cnt;
    pwr_done = 1'b0;
    if (power_down != pwr_cur && pwr_cnt == 3'h0) begin
      next_pwr_cnt = 3'(`PPI_PWR_CYCLES); // R6
    end else if (pwr_cnt == 3'h1) begin
      next_pwr_cnt = 3'h0;
      next_pwr_cur = power_down;
      pwr_done = 1'b1; // R7
    end else if (pwr_cnt != 3'h0) begin
      next_pwr_cnt = pwr_cnt - 3'h1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_cur <= `PPI_P1;
      pwr_cnt <= 3'h0;
    end else begin
      pwr_cur <= next_pwr_cur;
      pwr_cnt <= next_pwr_cnt;
    end
  end

  // ----------------------------------------
  // Word aligner on K28.5
  // ----------------------------------------
  ppi_sync_t sync_state; // Aligner state
  ppi_sync_t next_sync_state;
  logic [1:0] comma_cnt; // Good commas seen
  logic [1:0] next_comma_cnt;
  logic is_comma;

  assign is_comma = (pma_rx_word == `PPI_K285_NEG) ||
                    (pma_rx_word == `PPI_K285_POS); // R10

  // Lock after commas, drop on decode errors
  always_comb begin
    next_sync_state = sync_state;
    next_comma_cnt = comma_cnt;
    unique case (sync_state)
      PPI_UNSYNC: begin
        if (pma_rx_valid && is_comma) begin
          next_sync_state = PPI_HUNT; // R10
          next_comma_cnt = 2'h1;
        end
      end
      PPI_HUNT: begin
        if (pma_rx_valid && rx_dec_err) begin
          next_sync_state = PPI_UNSYNC;
        end else if (pma_rx_valid && is_comma) begin
          next_comma_cnt = comma_cnt + 2'h1;
          if (comma_cnt == 2'h3) begin
            next_sync_state = PPI_LOCKED;
          end
        end
      end
      PPI_LOCKED: begin
        if (pma_rx_valid && rx_dec_err) begin
          next_sync_state = PPI_UNSYNC;
          next_comma_cnt = 2'h0;
        end
      end
      default: begin
        next_sync_state = PPI_UNSYNC;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_state <= PPI_UNSYNC;
      comma_cnt <= 2'h0;
    end else begin
      sync_state <= next_sync_state;
      comma_cnt <= next_comma_cnt;
    end
  end

  // ----------------------------------------
  // Receive buffer toward the MAC
  // ----------------------------------------
  logic buf_in_ready; // Not-full flag; its inverse is reported as overflow
  logic buf_out_valid;
  logic [DW:0] buf_out;

  // Always in path; no bypass exists
  ppi_skid #(.W(DW + 1)) u_rx_buf ( // R2
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(pma_rx_valid && sync_state == PPI_LOCKED),
    .in_ready(buf_in_ready),
    .in_data({rx_dec_k, rx_dec_data}),
    .out_valid(buf_out_valid),
    .out_ready(rx_ready),
    .out_data(buf_out)
  );

  // ----------------------------------------
  // Status priority encoder
  // ----------------------------------------
  function automatic logic [2:0] ppi_status(input logic det, input logic hit,
      input logic dec, input logic disp, input logic ovf, input logic udf,
      input logic add, input logic drop);
    if (det) return hit ? `PPI_RXS_DETECTED : `PPI_RXS_OK;
    if (dec) return `PPI_RXS_DEC_ERR;
    if (ovf) return `PPI_RXS_OVERFLOW;
    if (udf) return `PPI_RXS_UNDERFLOW;
    if (disp) return `PPI_RXS_DISP_ERR;
    if (add) return `PPI_RXS_SKP_ADD;
    if (drop) return `PPI_RXS_SKP_DROP;
    return `PPI_RXS_OK;
  endfunction

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  logic det_done;
  logic next_idle;
  assign det_done = (det_state == PPI_SENSE) && (next_det_state == PPI_REPORT);
  // Idle on request, in any low-power state, or while detecting
  assign next_idle = tx_elecidle || (pwr_cur != `PPI_P0) ||
                     (det_state != PPI_IDLE); // R3 R17 R6

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      enc_data <= '0;
      enc_k <= 1'b0;
      enc_disp_force <= 1'b0;
      enc_disp_neg <= 1'b0;
      tx_buf_idle <= 1'b1;
      det_start <= 1'b0;
      loopback_on <= 1'b0;
      rm_low_latency <= 1'b0;
      rx_synced <= 1'b0;
      rx_data <= '0;
      rx_datak <= 1'b0;
      rx_valid <= 1'b0;
      phy_status <= 1'b0;
      rx_status <= `PPI_RXS_OK;
    end else begin
      // Loopback data replaces MAC data in P0
      enc_data <= loopback_on ? rx_dec_data : tx_data; // R15
      enc_k <= loopback_on ? rx_dec_k : tx_datak;
      enc_disp_force <= tx_compliance; // R5
      enc_disp_neg <= tx_compliance; // R5
      tx_buf_idle <= next_idle; // R3 R17
      det_start <= det_state == PPI_CHARGE; // R4
      loopback_on <= tx_detect_loop && pwr_cur == `PPI_P0 && !rate_gen2; // R15
      rm_low_latency <= low_latency; // R12
      rx_synced <= sync_state == PPI_LOCKED; // R10
      rx_data <= buf_out[DW-1:0]; // R9 R13
      rx_datak <= buf_out[DW];
      rx_valid <= buf_out_valid && rx_ready;
      phy_status <= det_done || pwr_done; // R7 R18
      rx_status <= ppi_status(det_done, next_det_found, rx_dec_err,
          rx_disp_err, rx_rm_over || !buf_in_ready, rx_rm_under,
          rx_rm_add, rx_rm_drop); // R8 R11
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_idle_follow: assert property (@(posedge mclk) disable iff (sys_rst) // R17
    tx_elecidle |=> tx_buf_idle) else $error("idle not forced");
  a_phy_pulse: assert property (@(posedge mclk) disable iff (sys_rst) // R18
    phy_status |=> !phy_status) else $error("status too long");
  a_lowpwr_idle: assert property (@(posedge mclk) disable iff (sys_rst) // R6
    pwr_cur != `PPI_P0 |=> tx_buf_idle) else $error("active in low power");
  a_det_p1: assert property (@(posedge mclk) disable iff (sys_rst) // R4
    det_state == PPI_IDLE && det_req |=> ##1 det_start) else $error("late");
  a_loop_p0: assert property (@(posedge mclk) disable iff (sys_rst) // R15
    loopback_on |-> $past(pwr_cur) == `PPI_P0) else $error("bad loopback");
  a_disp_ovr: assert property (@(posedge mclk) disable iff (sys_rst) // R5
    tx_compliance |=> enc_disp_force) else $error("no disparity ctl");
  a_det_done: assert property (@(posedge mclk) disable iff (sys_rst) // R7 R8
    det_done |=> phy_status && rx_status == (det_found ? `PPI_RXS_DETECTED :
    `PPI_RXS_OK)) else $error("no done");
  a_comma_lock: assert property (@(posedge mclk) disable iff (sys_rst) // R10
    sync_state == PPI_UNSYNC |=> !rx_synced) else $error("early lock");
endmodule

// *** ppi_channel_bench.sv ***
`include "ppi_params.svh"
module ppi_channel_bench import ppi_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Stimulus and state
  // ----------------------------------------
  logic mclk = 1'b0, sys_rst = 1'b1; // Reset held from time zero
  logic [7:0] tx_data = 8'h00, rx_dec_data = 8'h00;
  logic tx_datak = 1'b0, tx_elecidle = 1'b0, tx_compliance = 1'b0;
  logic tx_detect_loop = 1'b0, rate_gen2 = 1'b0, low_latency = 1'b0;
  logic [1:0] power_down = `PPI_P1; // Link starts in P1
  logic [9:0] pma_rx_word = 10'h000;
  logic pma_rx_valid = 1'b0, rx_dec_k = 1'b0, far_rx_present = 1'b0;
  logic stall = 1'b0, det_tick, rx_ready; // Stall steers the model
  logic [5:0] ev = 6'h00; // One bit per receive event
  logic [7:0] enc_data, rx_data;
  logic enc_k, enc_disp_force, enc_disp_neg, tx_buf_idle, det_start;
  logic loopback_on;
  logic rm_low_latency, rx_synced, rx_datak, rx_valid, phy_status;
  logic [2:0] rx_status;
  logic [2:0] evc [6] = '{`PPI_RXS_DEC_ERR, `PPI_RXS_DISP_ERR,
    `PPI_RXS_SKP_ADD, `PPI_RXS_SKP_DROP, `PPI_RXS_OVERFLOW,
    `PPI_RXS_UNDERFLOW}; // Code expected for each event bit
  logic [1:0] pst [3] = '{`PPI_P0S, `PPI_P2, `PPI_P1};
  logic [8:0] exp_q [$]; // Words sent, awaiting the model
  int seed = 32'h509D, miscompares = 0, compares = 0, cycles = 0, n;
  always #5 mclk = ~mclk;
  ppi_channel #(.DW(8), .LANES(1), .DET_CYCLES(2)) i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .tx_data(tx_data),
    .tx_datak(tx_datak), .tx_elecidle(tx_elecidle),
    .tx_compliance(tx_compliance), .tx_detect_loop(tx_detect_loop),
    .power_down(power_down), .rate_gen2(rate_gen2),
    .low_latency(low_latency), .pma_rx_word(pma_rx_word),
    .pma_rx_valid(pma_rx_valid), .rx_dec_err(ev[0]),
    .rx_disp_err(ev[1]), .rx_rm_add(ev[2]), .rx_rm_drop(ev[3]),
    .rx_rm_over(ev[4]), .rx_rm_under(ev[5]), .rx_dec_data(rx_dec_data),
    .rx_dec_k(rx_dec_k), .det_tick(det_tick),
    .far_rx_present(far_rx_present), .rx_ready(rx_ready),
    .enc_data(enc_data), .enc_k(enc_k), .enc_disp_force(enc_disp_force),
    .enc_disp_neg(enc_disp_neg), .tx_buf_idle(tx_buf_idle),
    .det_start(det_start),
    .loopback_on(loopback_on), .rm_low_latency(rm_low_latency),
    .rx_synced(rx_synced), .rx_data(rx_data), .rx_datak(rx_datak),
    .rx_valid(rx_valid), .phy_status(phy_status), .rx_status(rx_status));
  ppi_mac_model i_mac (
    .mclk(mclk), .sys_rst(sys_rst), .stall(stall), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_datak(rx_datak), .rx_ready(rx_ready),
    .det_tick(det_tick));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [9:0] got,
      input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle(input int k);
    repeat (k) @(negedge mclk);
  endtask
  // Status for a set of event bits, highest priority first
  function automatic logic [2:0] exp_status(input logic [5:0] e);
    if (e[0]) return `PPI_RXS_DEC_ERR;
    if (e[4]) return `PPI_RXS_OVERFLOW;
    if (e[5]) return `PPI_RXS_UNDERFLOW;
    if (e[1]) return `PPI_RXS_DISP_ERR;
    if (e[2]) return `PPI_RXS_SKP_ADD;
    if (e[3]) return `PPI_RXS_SKP_DROP;
    return `PPI_RXS_OK;
  endfunction
  // Detection report for a far end present or absent
  function automatic logic [2:0] exp_det(input logic present);
    return present ? `PPI_RXS_DETECTED : `PPI_RXS_OK;
  endfunction
  // Counts falling edges until the completion pulse, bounded
  task automatic wait_phy();
    n = 0;
    while (phy_status !== 1'b1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
  endtask
  // Power change: pulse lands five cycles on, lasts one
  task automatic go_power(input logic [1:0] p);
    power_down = p;
    wait_phy();
    check("phy_lat", 10'(n), 10'h005);
    settle(1);
    check("phy_one", phy_status, 1'b0);
    settle(1);
    check("idle_pwr", tx_buf_idle, p != `PPI_P0);
  endtask
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard, generous against the planned run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    settle(2);
    check("rst_idle", tx_buf_idle, 1'b1);
    check("rst_stat", {phy_status, rx_valid, rx_status}, 5'h00);
    settle(2);
    sys_rst = 1'b0;
    go_power(`PPI_P0);
    tx_elecidle = 1'b1;
    settle(1);
    check("idle_req", tx_buf_idle, 1'b1);
    settle(3);
    check("idle_hold", tx_buf_idle, 1'b1);
    tx_elecidle = 1'b0;
    foreach (pst[i]) go_power(pst[i]);
    // Receiver detection, far end absent then present
    for (int f = 0; f < 2; f++) begin
      far_rx_present = f[0];
      settle(4);
      tx_detect_loop = 1'b1;
      settle(2);
      check("det_start", det_start, 1'b1);
      wait_phy();
      check("det_stat", rx_status, exp_det(far_rx_present));
      check("det_idle", tx_buf_idle, 1'b1);
      tx_detect_loop = 1'b0;
      settle(3);
    end
    // Loopback only in P0 at Gen1
    go_power(`PPI_P0);
    tx_detect_loop = 1'b1;
    settle(3);
    check("loop_on", {loopback_on, det_start}, 2'b10);
    // Received symbol goes back out in place of MAC data
    {rx_dec_k, rx_dec_data} = 9'h1A5;
    settle(1);
    check("loop_data", {enc_k, enc_data}, 9'h1A5);
    rate_gen2 = 1'b1;
    settle(3);
    check("loop_gen2", loopback_on, 1'b0);
    tx_detect_loop = 1'b0;
    rate_gen2 = 1'b0;
    // Transmit path and mode bits, random
    repeat (24) begin
      {tx_datak, tx_data} = 9'($random(seed));
      {tx_compliance, low_latency} = 2'($random(seed));
      settle(1);
      check("enc", {enc_k, enc_data}, {tx_datak, tx_data});
      check("disp_force", enc_disp_force, tx_compliance);
      check("disp_neg", enc_disp_neg, tx_compliance);
      check("low_lat", rm_low_latency, low_latency);
    end
    // Commas of both disparities bring lock
    pma_rx_valid = 1'b1;
    for (int i = 0; i < 6; i++) begin
      pma_rx_word = i[0] ? `PPI_K285_POS : `PPI_K285_NEG;
      settle(1);
    end
    pma_rx_valid = 1'b0;
    settle(3);
    check("synced", rx_synced, 1'b1);
    i_mac.seen.delete();
    // Fill both entries while the model stalls, then drain
    repeat (12) begin
      stall = 1'b1;
      settle(2);
      repeat (2) begin
        {rx_dec_k, rx_dec_data} = 9'($random(seed));
        pma_rx_valid = 1'b1;
        exp_q.push_back({rx_dec_k, rx_dec_data});
        settle(1);
      end
      pma_rx_valid = 1'b0;
      settle(3);
      check("stall_hold", 10'(i_mac.seen.size()), 10'h000);
      stall = 1'b0;
      settle(6);
      check("rx_count", 10'(i_mac.seen.size()), 10'(exp_q.size()));
      while (exp_q.size() > 0 && i_mac.seen.size() > 0)
        check("rx_word", i_mac.seen.pop_front(), exp_q.pop_front());
      exp_q.delete();
    end
    // Each receive event gives its own status code
    foreach (evc[i]) begin
      ev = 6'(1 << i);
      settle(1);
      ev = 6'h00;
      n = 0;
      while (rx_status !== evc[i] && n < 4) begin
        settle(1);
        n++;
      end
      check("ev_code", rx_status, evc[i]);
    end
    // Random event mixes must follow the priority order
    repeat (8) begin
      ev = 6'($random(seed));
      settle(1);
      check("ev_prio", rx_status, exp_status(ev));
    end
    ev = 6'h00;
    results();
  end
endmodule

// *** ppi_mac_model.sv ***
`include "ppi_params.svh"
module ppi_mac_model import ppi_pkg::*; (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic stall,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_datak,
  output logic rx_ready,
  output logic det_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Receive side of the link layer
  // ----------------------------------------
  logic [8:0] seen [$]; // Words taken, oldest first
  initial begin
    rx_ready = 1'b0;
    det_tick = 1'b0;
  end
  // Detect clock runs free at 125 MHz, unrelated to mclk
  always #4 det_tick = ~det_tick;
  // Ready follows stall on the rising edge; stall is set mid-cycle
  always @(posedge mclk) begin
    rx_ready <= !stall && !sys_rst;
  end
  // Each valid pulse is a word already taken from the buffer
  always @(posedge mclk) begin
    if (!sys_rst && rx_valid === 1'b1) begin
      seen.push_back({rx_datak, rx_data});
    end
  end
endmodule

// *** ppi_params.svh ***
`ifndef PPI_PARAMS_SVH
`define PPI_PARAMS_SVH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define PPI_CLK_MHZ 100
`define PPI_DET_TIME_NS 1000
`define PPI_DET_CYCLES ((`PPI_DET_TIME_NS * `PPI_CLK_MHZ) / 1000)
`define PPI_PWR_CYCLES 4
// ----------------------------------------
// Receiver status codes
// ----------------------------------------
`define PPI_RXS_OK 3'h0
`define PPI_RXS_SKP_ADD 3'h1
`define PPI_RXS_SKP_DROP 3'h2
`define PPI_RXS_DETECTED 3'h3
`define PPI_RXS_DEC_ERR 3'h4
`define PPI_RXS_OVERFLOW 3'h5
`define PPI_RXS_UNDERFLOW 3'h6
`define PPI_RXS_DISP_ERR 3'h7
// ----------------------------------------
// Power state encodings
// ----------------------------------------
`define PPI_P0 2'h0
`define PPI_P0S 2'h1
`define PPI_P1 2'h2
`define PPI_P2 2'h3
// ----------------------------------------
// Comma and rate match
// ----------------------------------------
`define PPI_K285_NEG 10'h17C
`define PPI_K285_POS 10'h283
`define PPI_RM_PPM 300
`endif

// *** ppi_pkg.sv ***
`include "ppi_params.svh"
package ppi_pkg;
  // Detection sequencer states, Gray ordered
  typedef enum logic [1:0] {
    PPI_IDLE = 2'b00,
    PPI_CHARGE = 2'b01,
    PPI_SENSE = 2'b11,
    PPI_REPORT = 2'b10
  } ppi_det_t;
  // Aligner states
  typedef enum logic [1:0] {
    PPI_UNSYNC = 2'b00,
    PPI_HUNT = 2'b01,
    PPI_LOCKED = 2'b11
  } ppi_sync_t;
endpackage

// *** ppi_skid.sv ***
`include "ppi_params.svh"
module ppi_skid import ppi_pkg::*; #(
  parameter int W = 9
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  // ----------------------------------------
  // Two-entry buffer
  // ----------------------------------------
  logic [W-1:0] mem [2]; // Storage slots
  logic [1:0] count; // Words held
  logic rd_ptr; // Read slot
  logic wr_ptr; // Write slot
  logic [1:0] next_count;
  logic next_rd_ptr;
  logic next_wr_ptr;
  logic push;
  logic pop;

  // Handshake decode
  always_comb begin
    push = in_valid && (count != 2'h2);
    pop = (count != 2'h0) && out_ready;
    next_count = count + {1'b0, push} - {1'b0, pop};
    next_wr_ptr = wr_ptr ^ push;
    next_rd_ptr = rd_ptr ^ pop;
  end

  // State registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 2'h0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
    end else begin
      count <= next_count;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
    end
  end

  // Data storage, no reset needed
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];
endmodule
